/* File: src/mtbt_branch.sv */
// Branch condition and target calculation for the sequencer
`timescale 1ns/100ps
module mtbt_branch (
	input mtbt_pkg::mtbt_br_t kind,
	input wire logic [1:0] len,
	input wire logic [15:0] pcNext,
	input wire logic [7:0] opcode,
	input wire logic [7:0] opByte1,
	input wire logic [7:0] opByte2,
	input wire logic [7:0] accValue,
	input wire logic [15:0] dptrValue,
	input wire logic carryFlag,
	input wire logic bitValue,
	input wire logic cmpUnequal,
	input wire logic decNonzero,
	output logic [15:0] target,
	output logic taken
);
	logic [7:0] rel; // Displacement is always the last byte
	logic [15:0] relTarget; // Sign-extended relative destination
	assign rel = (len == mtbt_pkg::LEN_3) ? opByte2 : opByte1;
	assign relTarget = pcNext + {{8{rel[7]}}, rel};

	// Condition select; conditional forms fall through when not taken
	always_comb begin
		target = relTarget;
		taken = 1'b0;
		case (kind)
			mtbt_pkg::BR_NONE: target = pcNext;
			mtbt_pkg::BR_REL: taken = 1'b1;
			mtbt_pkg::BR_ABS: begin
				taken = 1'b1;
				target = {pcNext[mtbt_pkg::KEEP_MSB:mtbt_pkg::KEEP_LSB],
					opcode[mtbt_pkg::PAGE_MSB:mtbt_pkg::PAGE_LSB], opByte1};
			end
			mtbt_pkg::BR_LONG: begin
				taken = 1'b1;
				target = {opByte1, opByte2};
			end
			mtbt_pkg::BR_IND: begin
				taken = 1'b1;
				target = dptrValue + {8'h00, accValue};
			end
			mtbt_pkg::BR_CSET: taken = carryFlag;
			mtbt_pkg::BR_CCLR: taken = !carryFlag;
			mtbt_pkg::BR_BSET: taken = bitValue;
			mtbt_pkg::BR_BSETCLR: taken = bitValue;
			mtbt_pkg::BR_BCLR: taken = !bitValue;
			mtbt_pkg::BR_AZERO: taken = (accValue == 8'h00);
			mtbt_pkg::BR_ANZ: taken = (accValue != 8'h00);
			mtbt_pkg::BR_CMP: taken = cmpUnequal;
			mtbt_pkg::BR_DEC: taken = decNonzero;
			default: target = pcNext;
		endcase
	end
endmodule

/* File: src/mtbt_core.sv */
// Fetch and cycle sequencer for transfer, bit and branch instructions
`timescale 1ns/100ps
module mtbt_core (
	input wire logic clk,
	input wire logic rst_n,
	output logic [15:0] codeAddr,
	input wire logic [7:0] codeData,
	input wire logic [7:0] accValue,
	input wire logic [15:0] dptrValue,
	input wire logic carryFlag,
	input wire logic bitValue,
	input wire logic cmpUnequal,
	input wire logic decNonzero,
	output logic instrStart,
	output logic instrLast,
	output logic retire,
	output logic [7:0] opcode,
	output logic [7:0] opByte1,
	output logic [7:0] opByte2,
	output logic [15:0] progCounter,
	output logic branchTaken,
	output logic bitClearReq,
	output logic [7:0] tableData,
	output logic tableValid,
	output logic unknownOp
);
	// Position within the current instruction, zero on its first cycle
	logic [2:0] cycCnt;
	// Decode of the byte on the code bus, only meaningful in cycle zero
	mtbt_pkg::mtbt_dec_t liveDec;
	// Decode held for the remaining cycles of the instruction
	mtbt_pkg::mtbt_dec_t latDec;
	// Decode in force this cycle
	mtbt_pkg::mtbt_dec_t curDec;
	// Opcode in force this cycle
	logic [7:0] curOp;
	// First and last cycle markers
	logic isStart;
	logic isLast;
	// Sequential successor address
	logic [15:0] pcPlusLen;
	// Branch unit answers
	logic [15:0] brTarget;
	logic brTaken;
	// Code-table lookup
	logic isTableOp;
	logic [15:0] tableAddr;
	// Next counter value, chosen at the last cycle
	logic [15:0] next_progCounter;

	// Opcode table lookup on the live code byte
	mtbt_decode u_decode (
		.opcode(codeData),
		.dec(liveDec)
	);

	assign isStart = (cycCnt == 3'h0);
	assign curDec = isStart ? liveDec : latDec;
	assign curOp = isStart ? codeData : opcode;
	// One-cycle instructions are first and last at once
	assign isLast = (cycCnt == curDec.cycles - mtbt_pkg::CYC_1);
	assign instrStart = isStart;
	assign instrLast = isLast;
	assign pcPlusLen = progCounter + {14'h0000, curDec.len};

	// Operand bytes are read from the operand registers, so the
	// branch unit sees the first operand from cycle two and the second
	// from cycle three; every branch lasts longer than its length, which makes this safe.
	mtbt_branch u_branch (
		.kind(curDec.kind),
		.len(curDec.len),
		.pcNext(pcPlusLen),
		.opcode(curOp),
		.opByte1(opByte1),
		.opByte2(opByte2),
		.accValue(accValue),
		.dptrValue(dptrValue),
		.carryFlag(carryFlag),
		.bitValue(bitValue),
		.cmpUnequal(cmpUnequal),
		.decNonzero(decNonzero),
		.target(brTarget),
		.taken(brTaken)
	);

	// Table base: the data pointer, or the address after the opcode
	assign isTableOp = (opcode == mtbt_pkg::OP_TABLE_DATA_POINTER_REG) ||
		(opcode == mtbt_pkg::OP_TABLE_PC);
	assign tableAddr = (opcode == mtbt_pkg::OP_TABLE_DATA_POINTER_REG) ?
		dptrValue + {8'h00, accValue} : pcPlusLen + {8'h00, accValue};

	// Code bus address: instruction bytes first, then any table byte.
	// Kept combinational because the memory answers in the same cycle.
	always_comb begin
		if (cycCnt < {1'b0, curDec.len}) begin
			codeAddr = progCounter + {13'h0000, cycCnt};
		end else if (isTableOp && cycCnt == mtbt_pkg::TABLE_CYC) begin
			codeAddr = tableAddr;
		end else begin
			codeAddr = progCounter;
		end
	end

	// Cycle counter; the length of a branch never depends on the
	// outcome, so the count restarts only at the decoded last cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cycCnt <= 3'h0;
		end else if (isLast) begin
			cycCnt <= 3'h0;
		end else begin
			cycCnt <= cycCnt + 3'h1;
		end
	end

	// Opcode and its decode are held from the first cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			opcode <= 8'h00;
			latDec <= '{mtbt_pkg::LEN_1, mtbt_pkg::CYC_1,
				mtbt_pkg::BR_NONE, 1'b1};
		end else if (isStart) begin
			opcode <= codeData;
			latDec <= liveDec;
		end
	end

	// Operand bytes captured in the cycle that fetches them
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			opByte1 <= 8'h00;
			opByte2 <= 8'h00;
		end else begin
			if (cycCnt == 3'h1 && curDec.len > mtbt_pkg::LEN_1) begin
				opByte1 <= codeData;
			end
			if (cycCnt == 3'h2 && curDec.len > mtbt_pkg::LEN_2) begin
				opByte2 <= codeData;
			end
		end
	end

	// Successor: branch target if taken, else the next sequential
	always_comb begin
		if (brTaken) begin
			next_progCounter = brTarget;
		end else begin
			next_progCounter = pcPlusLen;
		end
	end

	// Program counter moves only at the end of an instruction
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			progCounter <= mtbt_pkg::PC_RESET;
		end else if (isLast) begin
			progCounter <= next_progCounter;
		end
	end

	// Retire strobe and outcome, one cycle after the last cycle so
	// that every operand register is already settled
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			retire <= 1'b0;
			branchTaken <= 1'b0;
			unknownOp <= 1'b0;
		end else begin
			retire <= isLast;
			branchTaken <= isLast && brTaken;
			unknownOp <= isLast && !curDec.known;
		end
	end

	// Test-and-clear: ask the bit store to clear a bit found set
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bitClearReq <= 1'b0;
		end else begin
			bitClearReq <= isLast && bitValue &&
				curDec.kind == mtbt_pkg::BR_BSETCLR;
		end
	end

	// Code-table byte captured from the second read of the code bus
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tableData <= 8'h00;
			tableValid <= 1'b0;
		end else begin
			tableValid <= isTableOp && cycCnt == mtbt_pkg::TABLE_CYC;
			if (isTableOp && cycCnt == mtbt_pkg::TABLE_CYC) begin
				tableData <= codeData;
			end
		end
	end

	// Register copies with the accumulator finish in one cycle
	a_copy_reg_time:
	assert property (@(posedge clk) disable iff (!rst_n)
		isStart && (codeData[7:3] == mtbt_pkg::OPG_A_FROM_REG ||
		codeData[7:3] == mtbt_pkg::OPG_REG_FROM_A) |=> isStart)
		else $error("register copy not one cycle");

	// Direct load of the accumulator: two cycles, counter plus two
	a_direct_load_span:
	assert property (@(posedge clk) disable iff (!rst_n)
		isStart && codeData == mtbt_pkg::OP_COPY_A_DIR |=>
		!isStart ##1 isStart && progCounter == $past(progCounter, 2) + 16'h2)
		else $error("direct acc load span wrong");

	// Direct to direct: three cycles, three bytes
	a_dir_dir_span:
	assert property (@(posedge clk) disable iff (!rst_n)
		isStart && codeData == mtbt_pkg::OP_COPY_DIR_DIR |=>
		!isStart[*2] ##1 progCounter == $past(progCounter, 3) + 16'h3)
		else $error("direct to direct span wrong");

	// Immediate into a direct byte: three cycles
	a_imm_dir_time:
	assert property (@(posedge clk) disable iff (!rst_n)
		isStart && codeData == mtbt_pkg::OP_COPY_DIR_IMM |=>
		!isStart[*2] ##1 isStart)
		else $error("immediate to direct not three cycles");

	// Direct byte into indirect RAM: three cycles
	a_ind_write_time:
	assert property (@(posedge clk) disable iff (!rst_n)
		isStart && codeData[7:1] == mtbt_pkg::OPH_IND_FROM_DIR |=>
		!isStart[*2] ##1 isStart)
		else $error("direct to indirect not three cycles");

	// Pointer load: three cycles, both constant bytes fetched
	a_pointer_load:
	assert property (@(posedge clk) disable iff (!rst_n)
		isStart && codeData == mtbt_pkg::OP_LOAD_POINTER |=>
		!isStart ##1 !isStart ##1 isStart &&
		progCounter == $past(progCounter, 3) + 16'h3)
		else $error("pointer load span wrong");

	// Table reads: five cycles from pointer, four from counter
	a_table_data_pointer_reg_time:
	assert property (@(posedge clk) disable iff (!rst_n)
		isStart && codeData == mtbt_pkg::OP_TABLE_DATA_POINTER_REG |=>
		!isStart ##1 (tableValid && !isStart) ##1
		!isStart[*2] ##1 isStart)
		else $error("pointer table read not five cycles");
	a_table_pc_time:
	assert property (@(posedge clk) disable iff (!rst_n)
		isStart && codeData == mtbt_pkg::OP_TABLE_PC |=>
		!isStart[*3] ##1 isStart)
		else $error("counter table read not four cycles");

	// External read through the data pointer: three cycles
	a_xram_read_time:
	assert property (@(posedge clk) disable iff (!rst_n)
		isStart && codeData == mtbt_pkg::OP_XRAM_RD_PTR |=>
		!isStart[*2] ##1 isStart)
		else $error("external read not three cycles");

	// External write through the data pointer: four cycles
	a_xram_write_time:
	assert property (@(posedge clk) disable iff (!rst_n)
		isStart && codeData == mtbt_pkg::OP_XRAM_WR_PTR |=>
		!isStart[*3] ##1 isStart)
		else $error("external write not four cycles");

	// Stack: push three cycles, pop two
	a_stack_time:
	assert property (@(posedge clk) disable iff (!rst_n)
		isStart && (codeData == mtbt_pkg::OP_STACK_PUSH ||
		codeData == mtbt_pkg::OP_STACK_POP) |=>
		!isStart ##1 (isStart == (opcode == mtbt_pkg::OP_STACK_POP)))
		else $error("stack timing wrong");

	// Swap with a direct byte: three cycles
	a_swap_dir_time:
	assert property (@(posedge clk) disable iff (!rst_n)
		isStart && codeData == mtbt_pkg::OP_SWAP_DIR |=>
		!isStart[*2] ##1 isStart)
		else $error("direct swap not three cycles");

	// Low-nibble swap: one byte, three cycles
	a_nibble_swap:
	assert property (@(posedge clk) disable iff (!rst_n)
		isStart && codeData[7:1] == mtbt_pkg::OPH_NIBBLE_SWAP |=>
		!isStart[*2] ##1 progCounter == $past(progCounter, 3) + 16'h1)
		else $error("nibble swap span wrong");

	// Carry clear one cycle; addressed bit clear three
	a_carry_bit_time:
	assert property (@(posedge clk) disable iff (!rst_n)
		isStart && (codeData == mtbt_pkg::OP_CLEAR_BIT ||
		codeData == mtbt_pkg::OP_CLEAR_CARRY) |=>
		if (opcode == mtbt_pkg::OP_CLEAR_CARRY) isStart
		else (!isStart[*2] ##1 isStart))
		else $error("carry or bit clear time wrong");

	// Bit copy into carry: two cycles
	a_bit_carry_time:
	assert property (@(posedge clk) disable iff (!rst_n)
		isStart && codeData == mtbt_pkg::OP_COPY_BIT_CARRY |=>
		!isStart ##1 isStart)
		else $error("bit copy not two cycles");

	// Carry branch: three cycles whatever the carry holds
	a_carry_branch:
	assert property (@(posedge clk) disable iff (!rst_n)
		isStart && codeData == mtbt_pkg::OP_BRANCH_CARRY |=>
		!isStart[*2] ##1 isStart)
		else $error("carry branch not three cycles");

	// Clear request only for a set bit in the test-and-clear form
	a_bit_clear_cause:
	assert property (@(posedge clk) disable iff (!rst_n)
		bitClearReq |-> retire && opcode == mtbt_pkg::OP_BIT_THEN_CLEAR &&
		$past(bitValue))
		else $error("bit clear without cause");

	// Long jump: four cycles, lands on the two address bytes
	a_long_jump:
	assert property (@(posedge clk) disable iff (!rst_n)
		isStart && codeData == mtbt_pkg::OP_LONG_JUMP |=>
		!isStart[*3] ##1 isStart && progCounter == {opByte1, opByte2})
		else $error("long jump wrong");

	// Indexed jump lands on pointer plus accumulator
	a_indexed_jump:
	assert property (@(posedge clk) disable iff (!rst_n)
		isLast && opcode == mtbt_pkg::OP_INDEXED_JUMP && !isStart |=>
		progCounter == $past(dptrValue) + {8'h00, $past(accValue)} &&
		$past(cycCnt) == mtbt_pkg::CYC_4)
		else $error("indexed jump wrong");

	// Accumulator zero branch: four cycles
	a_acc_zero_time:
	assert property (@(posedge clk) disable iff (!rst_n)
		isStart && codeData == mtbt_pkg::OP_ACC_ZERO |=>
		!isStart[*3] ##1 isStart)
		else $error("zero branch not four cycles");

	// Compare immediate with accumulator: four cycles
	a_compare_time:
	assert property (@(posedge clk) disable iff (!rst_n)
		isStart && codeData == mtbt_pkg::OP_CMP_A_IMM |=>
		!isStart[*3] ##1 isStart)
		else $error("compare branch not four cycles");

	// Decrement direct: five cycles
	a_decrement_time:
	assert property (@(posedge clk) disable iff (!rst_n)
		isStart && codeData == mtbt_pkg::OP_DEC_DIR |=>
		!isStart[*4] ##1 isStart)
		else $error("decrement branch not five cycles");

	// Non-branch instructions move the counter by their length
	a_seq_advance:
	assert property (@(posedge clk) disable iff (!rst_n)
		isLast && curDec.kind == mtbt_pkg::BR_NONE |=>
		progCounter == $past(progCounter) + {14'h0000, $past(curDec.len)})
		else $error("sequential advance wrong");
endmodule

/* File: src/mtbt_decode.sv */
// Opcode table: byte length, cycle count and branch kind
`timescale 1ns/100ps
module mtbt_decode (
	input wire logic [7:0] opcode,
	output mtbt_pkg::mtbt_dec_t dec
);
	// Short names so that each table entry fits on one line
	localparam logic [1:0] L1 = mtbt_pkg::LEN_1;
	localparam logic [1:0] L2 = mtbt_pkg::LEN_2;
	localparam logic [1:0] L3 = mtbt_pkg::LEN_3;
	localparam logic [2:0] C1 = mtbt_pkg::CYC_1;
	localparam logic [2:0] C2 = mtbt_pkg::CYC_2;
	localparam logic [2:0] C3 = mtbt_pkg::CYC_3;
	localparam logic [2:0] C4 = mtbt_pkg::CYC_4;
	localparam logic [2:0] C5 = mtbt_pkg::CYC_5;

	// Entry for an opcode that the table knows
	function automatic mtbt_pkg::mtbt_dec_t ent(input logic [1:0] l,
		input logic [2:0] c, input mtbt_pkg::mtbt_br_t k);
		return '{len: l, cycles: c, kind: k, known: 1'b1};
	endfunction

	// Pure lookup; lengths never depend on operands, so the core can
	// plan the whole fetch from the opcode byte alone
	always_comb begin
		casez (opcode)
			8'h00, 8'b1110_1???, 8'b1111_1???,
			8'hc3, 8'hd3, 8'hb3:
				dec = ent(L1, C1, mtbt_pkg::BR_NONE);
			8'he5, 8'h74, 8'b0111_1???, 8'hf5,
			8'b1000_1???, 8'h76, 8'h77,
			8'h82, 8'hb0, 8'h72, 8'ha0, 8'ha2,
			8'hd0:
				dec = ent(L2, C2, mtbt_pkg::BR_NONE);
			8'he6, 8'he7, 8'hf6, 8'hf7, 8'b1100_1???:
				dec = ent(L1, C2, mtbt_pkg::BR_NONE);
			8'b1010_1???, 8'h86, 8'h87, 8'ha6, 8'ha7,
			8'hc0, 8'hc5, 8'hc2, 8'hd2, 8'hb2, 8'h92:
				dec = ent(L2, C3, mtbt_pkg::BR_NONE);
			8'h85, 8'h75, 8'h90:
				dec = ent(L3, C3, mtbt_pkg::BR_NONE);
			8'h93, 8'hf2, 8'hf3:
				dec = ent(L1, C5, mtbt_pkg::BR_NONE);
			8'h83, 8'he2, 8'he3, 8'hf0:
				dec = ent(L1, C4, mtbt_pkg::BR_NONE);
			8'he0, 8'hc6, 8'hc7, 8'hd6, 8'hd7:
				dec = ent(L1, C3, mtbt_pkg::BR_NONE);
			8'h40: dec = ent(L2, C3, mtbt_pkg::BR_CSET);
			8'h50: dec = ent(L2, C3, mtbt_pkg::BR_CCLR);
			8'h20: dec = ent(L3, C5, mtbt_pkg::BR_BSET);
			8'h30: dec = ent(L3, C5, mtbt_pkg::BR_BCLR);
			8'h10: dec = ent(L3, C5, mtbt_pkg::BR_BSETCLR);
			8'b???0_0001: dec = ent(L2, C3, mtbt_pkg::BR_ABS);
			8'h02: dec = ent(L3, C4, mtbt_pkg::BR_LONG);
			8'h80: dec = ent(L2, C3, mtbt_pkg::BR_REL);
			8'h73: dec = ent(L1, C5, mtbt_pkg::BR_IND);
			8'h60: dec = ent(L2, C4, mtbt_pkg::BR_AZERO);
			8'h70: dec = ent(L2, C4, mtbt_pkg::BR_ANZ);
			8'hb5, 8'hb6, 8'hb7:
				dec = ent(L3, C5, mtbt_pkg::BR_CMP);
			8'hb4, 8'b1011_1???:
				dec = ent(L3, C4, mtbt_pkg::BR_CMP);
			8'b1101_1???: dec = ent(L2, C4, mtbt_pkg::BR_DEC);
			8'hd5: dec = ent(L3, C5, mtbt_pkg::BR_DEC);
			// Outside the table: runs as one byte, one cycle, flagged
			default: dec = '{L1, C1, mtbt_pkg::BR_NONE, 1'b0};
		endcase
	end
endmodule

/* File: src/mtbt_pkg.sv */
// Shared constants and types for the transfer and branch timing sequencer
package mtbt_pkg;
	// Instruction lengths in bytes
	localparam logic [1:0] LEN_1 = 2'h1;
	localparam logic [1:0] LEN_2 = 2'h2;
	localparam logic [1:0] LEN_3 = 2'h3;
	// Instruction durations in CPU cycles
	localparam logic [2:0] CYC_1 = 3'h1;
	localparam logic [2:0] CYC_2 = 3'h2;
	localparam logic [2:0] CYC_3 = 3'h3;
	localparam logic [2:0] CYC_4 = 3'h4;
	localparam logic [2:0] CYC_5 = 3'h5;
	// Cycle index in which a code-table byte is read
	localparam logic [2:0] TABLE_CYC = 3'h1;
	// Program counter after reset
	localparam logic [15:0] PC_RESET = 16'h0000;
	// Absolute jump: page bits in the opcode, kept bits of the counter
	localparam int PAGE_MSB = 7;
	localparam int PAGE_LSB = 5;
	localparam int KEEP_MSB = 15;
	localparam int KEEP_LSB = 11;
	// Opcodes and opcode groups that the sequencer checks by name
	localparam logic [4:0] OPG_A_FROM_REG = 5'h1d;
	localparam logic [4:0] OPG_REG_FROM_A = 5'h1f;
	localparam logic [7:0] OP_COPY_A_DIR = 8'he5;
	localparam logic [7:0] OP_COPY_DIR_DIR = 8'h85;
	localparam logic [7:0] OP_COPY_DIR_IMM = 8'h75;
	localparam logic [6:0] OPH_IND_FROM_DIR = 7'h53;
	localparam logic [7:0] OP_LOAD_POINTER = 8'h90;
	localparam logic [7:0] OP_TABLE_DATA_POINTER_REG = 8'h93;
	localparam logic [7:0] OP_TABLE_PC = 8'h83;
	localparam logic [7:0] OP_XRAM_RD_PTR = 8'he0;
	localparam logic [7:0] OP_XRAM_WR_PTR = 8'hf0;
	localparam logic [7:0] OP_STACK_PUSH = 8'hc0;
	localparam logic [7:0] OP_STACK_POP = 8'hd0;
	localparam logic [7:0] OP_SWAP_DIR = 8'hc5;
	localparam logic [6:0] OPH_NIBBLE_SWAP = 7'h6b;
	localparam logic [7:0] OP_CLEAR_CARRY = 8'hc3;
	localparam logic [7:0] OP_CLEAR_BIT = 8'hc2;
	localparam logic [7:0] OP_COPY_BIT_CARRY = 8'ha2;
	localparam logic [7:0] OP_BRANCH_CARRY = 8'h40;
	localparam logic [7:0] OP_BIT_THEN_CLEAR = 8'h10;
	localparam logic [7:0] OP_LONG_JUMP = 8'h02;
	localparam logic [7:0] OP_INDEXED_JUMP = 8'h73;
	localparam logic [7:0] OP_ACC_ZERO = 8'h60;
	localparam logic [7:0] OP_CMP_A_IMM = 8'hb4;
	localparam logic [7:0] OP_DEC_DIR = 8'hd5;
	// How an instruction changes the program counter
	typedef enum logic [3:0] {
		BR_NONE, BR_REL, BR_ABS, BR_LONG, BR_IND, BR_CSET, BR_CCLR,
		BR_BSET, BR_BCLR, BR_BSETCLR, BR_AZERO, BR_ANZ, BR_CMP, BR_DEC
	} mtbt_br_t;
	// Decoded length, duration, branch kind and table hit
	typedef struct packed {
		logic [1:0] len;
		logic [2:0] cycles;
		mtbt_br_t kind;
		logic known;
	} mtbt_dec_t;
endpackage

/* File: testbench/mcu_transfer_branch_timing_bench.sv */
// Random-program bench for the transfer and branch timing sequencer
`timescale 1ns/100ps
`define CHK(nm, e, g) \
	begin \
		checkCount++; \
		if ((g) !== (e)) begin \
			failCount++; \
			$display("[FAIL] %s expected %h seen %h", nm, e, g); \
		end \
	end
module mcu_transfer_branch_timing_bench;
	// Each round reloads random code and restarts from reset
	localparam int ROUNDS = 24;
	localparam int ROUND_CYC = 3000;
	// Rounds take about 72240 cycles; the margin catches a hang
	localparam int CYCLE_LIMIT = 80000;
	// Opcode placed at address zero of each round, one per group
	localparam logic [7:0] CORNER [ROUNDS] = '{
		8'he8, 8'he5, 8'ha8, 8'h85, 8'h75, 8'h90, 8'h93, 8'h83,
		8'he2, 8'he0, 8'hf2, 8'hf0, 8'hc0, 8'hd0, 8'hc8, 8'hd6,
		8'h92, 8'h10, 8'h73, 8'h60, 8'hb4, 8'hd5, 8'h02, 8'ha5};
	logic clk;
	logic rst_n;
	logic [15:0] codeAddr;
	logic [7:0] codeData;
	logic [7:0] accValue;
	logic [15:0] dptrValue;
	logic carryFlag;
	logic bitValue;
	logic cmpUnequal;
	logic decNonzero;
	logic instrStart;
	logic instrLast;
	logic retire;
	logic [7:0] opcode;
	logic [7:0] opByte1;
	logic [7:0] opByte2;
	logic [15:0] progCounter;
	logic branchTaken;
	logic bitClearReq;
	logic [7:0] tableData;
	logic tableValid;
	logic unknownOp;
	int failCount = 0;
	int checkCount = 0;
	int cycles = 0;
	int rstSeen = 0; // Reset cycles already seen by the monitor
	logic [15:0] lfsrState = 16'h7b0d; // Datapath sequence, starts at 31501
	logic [15:0] romSeed = 16'h7b0d; // Code image sequence
	// Monitor state for the instruction in flight
	logic [15:0] expPc;
	logic [15:0] startPc;
	logic [15:0] nxt;
	logic [15:0] tgt;
	logic [15:0] tAddr;
	logic [7:0] curOp;
	logic [7:0] b1;
	logic [7:0] b2;
	logic [7:0] rel;
	logic [2:0] cnt;
	logic pendRetire;
	logic inInstr;
	logic expTaken;
	logic expClr;
	logic tabOp; // Instruction in flight reads the code table
	mtbt_pkg::mtbt_dec_t curDec;

	mtbt_core i_dut (.clk(clk), .rst_n(rst_n), .codeAddr(codeAddr),
		.codeData(codeData), .accValue(accValue), .dptrValue(dptrValue),
		.carryFlag(carryFlag), .bitValue(bitValue), .cmpUnequal(cmpUnequal),
		.decNonzero(decNonzero), .instrStart(instrStart),
		.instrLast(instrLast), .retire(retire), .opcode(opcode),
		.opByte1(opByte1), .opByte2(opByte2), .progCounter(progCounter),
		.branchTaken(branchTaken), .bitClearReq(bitClearReq),
		.tableData(tableData), .tableValid(tableValid),
		.unknownOp(unknownOp));
	mtbt_code_rom i_rom (.codeAddr(codeAddr), .codeData(codeData));

	// Galois shift register step
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return (s >> 1) ^ (s[0] ? 16'hb400 : 16'h0000);
	endfunction

	function automatic mtbt_pkg::mtbt_dec_t mk(input logic [1:0] l,
		input logic [2:0] c, input mtbt_pkg::mtbt_br_t k);
		return '{len: l, cycles: c, kind: k, known: 1'b1};
	endfunction

	// Expected length, duration and branch kind of every opcode
	function automatic mtbt_pkg::mtbt_dec_t expect_dec(input logic [7:0] op);
		casez (op)
			8'h00, 8'b1110_1???, 8'b1111_1???, 8'hc3, 8'hd3, 8'hb3:
				return mk(2'h1, 3'h1, mtbt_pkg::BR_NONE);
			8'he5, 8'h74, 8'b0111_1???, 8'hf5, 8'b1000_1???, 8'h82, 8'hb0,
			8'h72, 8'ha0, 8'ha2, 8'hd0, 8'h76, 8'h77:
				return mk(2'h2, 3'h2, mtbt_pkg::BR_NONE);
			8'he6, 8'he7, 8'hf6, 8'hf7, 8'b1100_1???:
				return mk(2'h1, 3'h2, mtbt_pkg::BR_NONE);
			8'b1010_1???, 8'h86, 8'h87, 8'ha6, 8'ha7, 8'hc0, 8'hc5, 8'hc2,
			8'hd2, 8'hb2, 8'h92:
				return mk(2'h2, 3'h3, mtbt_pkg::BR_NONE);
			8'h85, 8'h75, 8'h90:
				return mk(2'h3, 3'h3, mtbt_pkg::BR_NONE);
			8'h93, 8'hf2, 8'hf3:
				return mk(2'h1, 3'h5, mtbt_pkg::BR_NONE);
			8'h83, 8'he2, 8'he3, 8'hf0:
				return mk(2'h1, 3'h4, mtbt_pkg::BR_NONE);
			8'he0, 8'hc6, 8'hc7, 8'hd6, 8'hd7:
				return mk(2'h1, 3'h3, mtbt_pkg::BR_NONE);
			8'h40: return mk(2'h2, 3'h3, mtbt_pkg::BR_CSET);
			8'h50: return mk(2'h2, 3'h3, mtbt_pkg::BR_CCLR);
			8'h20: return mk(2'h3, 3'h5, mtbt_pkg::BR_BSET);
			8'h30: return mk(2'h3, 3'h5, mtbt_pkg::BR_BCLR);
			8'h10: return mk(2'h3, 3'h5, mtbt_pkg::BR_BSETCLR);
			8'b???0_0001: return mk(2'h2, 3'h3, mtbt_pkg::BR_ABS);
			8'h02: return mk(2'h3, 3'h4, mtbt_pkg::BR_LONG);
			8'h80: return mk(2'h2, 3'h3, mtbt_pkg::BR_REL);
			8'h73: return mk(2'h1, 3'h5, mtbt_pkg::BR_IND);
			8'h60: return mk(2'h2, 3'h4, mtbt_pkg::BR_AZERO);
			8'h70: return mk(2'h2, 3'h4, mtbt_pkg::BR_ANZ);
			8'hb5, 8'hb6, 8'hb7: return mk(2'h3, 3'h5, mtbt_pkg::BR_CMP);
			8'hb4, 8'b1011_1???: return mk(2'h3, 3'h4, mtbt_pkg::BR_CMP);
			8'b1101_1???: return mk(2'h2, 3'h4, mtbt_pkg::BR_DEC);
			8'hd5: return mk(2'h3, 3'h5, mtbt_pkg::BR_DEC);
			// Outside the table: one byte, one cycle, flagged
			default: return '{2'h1, 3'h1, mtbt_pkg::BR_NONE, 1'b0};
		endcase
	endfunction

	// Whether a branch of this kind goes, from the levels seen now
	function automatic logic cond_of(input mtbt_pkg::mtbt_br_t k);
		case (k)
			mtbt_pkg::BR_NONE: return 1'b0;
			mtbt_pkg::BR_CSET: return carryFlag;
			mtbt_pkg::BR_CCLR: return !carryFlag;
			mtbt_pkg::BR_BSET, mtbt_pkg::BR_BSETCLR: return bitValue;
			mtbt_pkg::BR_BCLR: return !bitValue;
			mtbt_pkg::BR_AZERO: return accValue == 8'h00;
			mtbt_pkg::BR_ANZ: return accValue != 8'h00;
			mtbt_pkg::BR_CMP: return cmpUnequal;
			mtbt_pkg::BR_DEC: return decNonzero;
			default: return 1'b1;
		endcase
	endfunction

	// Verdict and end of run
	task summarize;
		if (failCount == 0 && checkCount > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// New datapath levels only between instructions, so they hold steady
	// through each one; zero accumulator is forced often on purpose
	always @(posedge clk) begin
		if (!rst_n || instrLast) begin
			lfsrState = lfsr_next(lfsrState);
			accValue <= (lfsrState[15:13] == 3'h0) ? 8'h00 : lfsrState[7:0];
			carryFlag <= lfsrState[8];
			bitValue <= lfsrState[9];
			cmpUnequal <= lfsrState[10];
			decNonzero <= lfsrState[11];
			lfsrState = lfsr_next(lfsrState);
			dptrValue <= lfsrState;
		end
	end

	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles >= CYCLE_LIMIT) begin
			failCount++;
			summarize();
		end
	end

	// Main sequence: reload code under reset, then let it run; the
	// reset in mid-run also cuts short any tight self-loop
	initial begin
		rst_n = 1'b0;
		accValue = 8'h00;
		dptrValue = 16'h0000;
		carryFlag = 1'b0;
		bitValue = 1'b0;
		cmpUnequal = 1'b0;
		decNonzero = 1'b0;
		for (int r = 0; r < ROUNDS; r++) begin
			rst_n <= 1'b0;
			for (int a = 0; a < 65536; a++) begin
				romSeed = lfsr_next(romSeed);
				i_rom.mem[a] = romSeed[7:0];
			end
			i_rom.mem[0] = CORNER[r];
			repeat (10) @(posedge clk);
			rst_n <= 1'b1;
			repeat (ROUND_CYC) @(posedge clk);
		end
		summarize();
	end

	// Monitor on the falling edge, where all outputs have settled
	always @(negedge clk) begin
		if (!rst_n) begin
			// Reset acts at an edge, so the first low cycle is skipped
			if (rstSeen != 0) begin
				`CHK("progCounter", mtbt_pkg::PC_RESET, progCounter)
				`CHK("instrStart", 1'b1, instrStart)
			end
			rstSeen = 1;
			pendRetire = 1'b0;
			inInstr = 1'b0;
			expPc = mtbt_pkg::PC_RESET;
		end else begin
			rstSeen = 0;
			if (pendRetire) begin
				`CHK("retire", 1'b1, retire)
				`CHK("progCounter", expPc, progCounter)
				`CHK("branchTaken", expTaken, branchTaken)
				`CHK("bitClearReq", expClr, bitClearReq)
				`CHK("unknownOp", ~curDec.known, unknownOp)
				`CHK("opcode", curOp, opcode)
				`CHK("instrStart", 1'b1, instrStart)
				if (curDec.len > 2'h1) `CHK("opByte1", b1, opByte1)
				if (curDec.len > 2'h2) `CHK("opByte2", b2, opByte2)
				pendRetire = 1'b0;
			end
			if (instrStart) begin
				`CHK("codeAddr", expPc, codeAddr)
				startPc = codeAddr;
				curOp = codeData;
				tabOp = curOp == mtbt_pkg::OP_TABLE_DATA_POINTER_REG ||
					curOp == mtbt_pkg::OP_TABLE_PC;
				curDec = expect_dec(codeData);
				tAddr = (curOp == mtbt_pkg::OP_TABLE_DATA_POINTER_REG) ? dptrValue :
					startPc + 16'h1;
				tAddr = tAddr + {8'h00, accValue};
				cnt = 3'h0;
				inInstr = 1'b1;
			end
			if (inInstr) begin
				cnt = cnt + 3'h1;
				// Table byte lands in the third cycle, and in no other
				`CHK("tableValid", tabOp && cnt == 3'h3, tableValid)
				if (tabOp && cnt == 3'h3) begin
					`CHK("tableData", i_rom.mem[tAddr], tableData)
				end
				if (cnt == curDec.cycles || instrLast) begin
					`CHK("instrLast", 1'b1, instrLast)
					`CHK("cycles", curDec.cycles, cnt)
					nxt = startPc + {14'h0, curDec.len};
					b1 = i_rom.mem[startPc + 16'h1];
					b2 = i_rom.mem[startPc + 16'h2];
					rel = i_rom.mem[nxt - 16'h1];
					expTaken = cond_of(curDec.kind);
					expClr = curDec.kind == mtbt_pkg::BR_BSETCLR && bitValue;
					case (curDec.kind)
						mtbt_pkg::BR_ABS: tgt = {nxt[15:11], curOp[7:5], b1};
						mtbt_pkg::BR_LONG: tgt = {b1, b2};
						mtbt_pkg::BR_IND: tgt = dptrValue + {8'h00, accValue};
						default: tgt = nxt + {{8{rel[7]}}, rel};
					endcase
					expPc = expTaken ? tgt : nxt;
					pendRetire = 1'b1;
					inInstr = 1'b0;
				end
			end
		end
	end
endmodule

/* File: testbench/mtbt_code_rom.sv */
// Behavioural code memory that answers the sequencer's fetch port
`timescale 1ns/100ps
module mtbt_code_rom (
	input wire logic [15:0] codeAddr,
	output logic [7:0] codeData
);
	// Full 64 KB image, rewritten by the bench only while the core is in reset
	logic [7:0] mem [0:65535];
	// Asynchronous read: the byte answers in the cycle of its address
	assign codeData = mem[codeAddr];
endmodule
